// ### verilog/rcp_regs.vh
`ifndef RCP_REGS_VH
`define RCP_REGS_VH
// ==========================================================
// Interface select codes, as iface_select_1, iface_select_0.
`define RCP_IF_SPI        2'b00
`define RCP_IF_UART       2'b01
`define RCP_IF_I2C        2'b10
`define RCP_IF_STANDALONE 2'b11
// ==========================================================
// Sound output configurations.
`define RCP_OUT_SPEAKER   2'b00
`define RCP_OUT_BUZZ2     2'b01
`define RCP_OUT_BUZZ4     2'b10
// ==========================================================
// Timing figures, in nanoseconds, and the clock period.
`define RCP_CLK_PERIOD_NS 100
`define RCP_RST_MIN_NS    1000
`define RCP_PROBE_NS      2000
// ==========================================================
// Sleep control pattern tracker states.
`define RCP_SLP_HIGH      2'b00
`define RCP_SLP_LOW       2'b01
`define RCP_SLP_ARMED     2'b10
// ==========================================================
// Idle level of each synchroniser bit, in the order of the raw input word.
`define RCP_SYNC_IDLE     16'h801c
`endif

// ### verilog/rcp_top.v
`timescale 1ns/10ps
`include "rcp_regs.vh"
module rcp_top #(
	parameter RST_MIN_CYC = (`RCP_RST_MIN_NS + `RCP_CLK_PERIOD_NS - 1) / `RCP_CLK_PERIOD_NS,
	parameter PROBE_CYC   = `RCP_PROBE_NS / `RCP_CLK_PERIOD_NS,
	parameter CNT_W       = 8
) (
	input  wire       clk_i,
	input  wire       rst_i,
	input  wire       reset_n_i,
	input  wire       por_hold_i,
	input  wire       bor_low_i,
	input  wire       resonator_select_i,
	input  wire [1:0] iface_select_i,
	input  wire       host_reset_cmd_i,
	input  wire       host_reset_forced_i,
	input  wire       sound_output_setup_request_i,
	input  wire [1:0] sound_out_cfg_i,
	input  wire       param_amp_enable_i,
	input  wire       activity_i,
	input  wire       fault_a_set_i,
	input  wire       fault_b_set_i,
	input  wire       flash_answer_i,
	input  wire       sleep_ctrl_i,
	input  wire       record_hold_n_i,
	input  wire       control_any_n_i,
	output reg        sys_reset_o,
	output reg        busy_o,
	output reg        amp_enable_out_o,
	output reg        amp_enable_out_oe_o,
	output reg        ext_flash_pins_oe_o,
	output reg        probe_active_o,
	output reg        clk_from_resonator_o,
	output reg        resonator_pins_en_o,
	output reg        fault_channel_a_o,
	output reg        fault_channel_b_o,
	output reg        error_o,
	output reg        recording_o,
	output reg        sleep_o,
	output reg        deep_sleep_o,
	output reg        speaker_oe_o,
	output reg        bz_pair1_oe_o,
	output reg        bz_pos_2_oe_o,
	output reg        bz_neg_2_oe_o,
	output reg  [1:0] iface_mode_o
);
	// ==========================================================
	// Input synchronisers: two flops on every pin input.
	// Activity and fault strobes come from logic on this clock and skip them.
	localparam SYNC_W = 16;
	wire [SYNC_W-1:0] raw_in;
	reg  [SYNC_W-1:0] sync_a;
	reg  [SYNC_W-1:0] sync_b;
	assign raw_in = {reset_n_i, por_hold_i, bor_low_i, resonator_select_i, iface_select_i,
		host_reset_cmd_i, host_reset_forced_i, sound_output_setup_request_i,
		param_amp_enable_i, flash_answer_i, sleep_ctrl_i, record_hold_n_i,
		control_any_n_i, sound_out_cfg_i};

	// Both stages load the idle level of each pin on reset, so releasing reset
	// shows no false command edge and no false supply fault to the logic.
	// Only stage two is read; stage one may go metastable.
	always @(posedge clk_i) begin
		if (rst_i) begin
			sync_a <= `RCP_SYNC_IDLE;
			sync_b <= `RCP_SYNC_IDLE;
		end else begin
			sync_a <= raw_in;
			sync_b <= sync_a;
		end
	end

	wire       s_reset_n   = sync_b[15];
	wire       s_por       = sync_b[14];
	wire       s_bor       = sync_b[13];
	wire       s_res_sel   = sync_b[12];
	wire [1:0] s_iface     = sync_b[11:10];
	wire       s_cmd       = sync_b[9];
	wire       s_forced    = sync_b[8];
	wire       s_setup_req = sync_b[7];
	wire       s_param_amp = sync_b[6];
	wire       s_answer    = sync_b[5];
	wire       s_sleep     = sync_b[4];
	wire       s_rec_n     = sync_b[3];
	wire       s_ctrl_n    = sync_b[2];
	wire [1:0] s_outcfg    = sync_b[1:0];

	// ==========================================================
	// Reset pin filter and host command edge detect.
	reg [CNT_W-1:0] low_cnt;
	reg             cmd_d;
	wire            cmd_edge = s_cmd & ~cmd_d;
	wire            pin_reset = (low_cnt >= RST_MIN_CYC[CNT_W-1:0]);
	wire            standalone = (s_iface == `RCP_IF_STANDALONE);
	wire            forced_rst = cmd_edge & s_forced & ~standalone;
	wire            next_reset = pin_reset | s_por | s_bor | forced_rst;

	// Count low time of the reset pin; short pulses never reach the limit.
	// The count stops at the limit, so a pin held low keeps reset asserted.
	// Host commands act only on the rising edge of the synchronised command.
	always @(posedge clk_i) begin
		if (rst_i) begin
			low_cnt <= {CNT_W{1'b0}};
			cmd_d   <= 1'b0;
		end else begin
			cmd_d <= s_cmd;
			if (s_reset_n)
				low_cnt <= {CNT_W{1'b0}};
			else if (!pin_reset)
				low_cnt <= low_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// Internal reset is registered so it releases on a clock edge.
	// Supply holds act as levels; the forced command is a one-cycle pulse,
	// which is enough because every flop past the synchronisers and reset filter resets from srst.
	always @(posedge clk_i) begin
		if (rst_i)
			sys_reset_o <= 1'b1;
		else
			sys_reset_o <= next_reset;
	end

	// Block-wide reset: the external reset or any internal reset cause.
	wire srst = rst_i | sys_reset_o;

	// ==========================================================
	// Flash probe after reset release.
	reg [CNT_W-1:0] probe_cnt;
	reg             probe_done;

	// The probe window opens at release; an answer keeps pins driven.
	// An answer that comes after the window has closed is ignored until the
	// next reset, so the flash pin state never changes once decided.
	// CNT_W must hold PROBE_CYC as well as the reset pin limit.
	always @(posedge clk_i) begin
		if (srst) begin
			probe_cnt           <= {CNT_W{1'b0}};
			probe_done          <= 1'b0;
			probe_active_o      <= 1'b1;
			ext_flash_pins_oe_o <= 1'b0;
		end else if (!probe_done) begin
			if (s_answer) begin
				probe_done          <= 1'b1;
				probe_active_o      <= 1'b0;
				ext_flash_pins_oe_o <= 1'b1;
			end else if (probe_cnt >= PROBE_CYC[CNT_W-1:0]) begin
				probe_done          <= 1'b1;
				probe_active_o      <= 1'b0;
				ext_flash_pins_oe_o <= 1'b0;
			end else begin
				probe_cnt <= probe_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// ==========================================================
	// Errors: set wins over a non-fatal clear in the same cycle.
	wire nf_clear = cmd_edge & ~s_forced & ~standalone;

	// Each channel keeps its flag until a non-fatal clear or any reset.
	// The error output is loaded with the next value of the channel flags,
	// so it always equals their OR without a cycle of lag.
	always @(posedge clk_i) begin
		if (srst) begin
			fault_channel_a_o <= 1'b0;
			fault_channel_b_o <= 1'b0;
			error_o           <= 1'b0;
		end else begin
			fault_channel_a_o <= fault_a_set_i | (fault_channel_a_o & ~nf_clear);
			fault_channel_b_o <= fault_b_set_i | (fault_channel_b_o & ~nf_clear);
			error_o <= fault_a_set_i | fault_b_set_i |
				((fault_channel_a_o | fault_channel_b_o) & ~nf_clear);
		end
	end

	// ==========================================================
	// Amplifier enable: driven with the activity level once released from high impedance.
	// Once driven, the pin stays driven until the next reset; its level follows
	// activity so an external amplifier only powers up while sound is made.
	always @(posedge clk_i) begin
		if (srst) begin
			amp_enable_out_oe_o <= 1'b0;
			amp_enable_out_o    <= 1'b0;
		end else begin
			if (!standalone && s_setup_req)
				amp_enable_out_oe_o <= 1'b1;
			else if (standalone && s_param_amp)
				amp_enable_out_oe_o <= 1'b1;
			amp_enable_out_o <= amp_enable_out_oe_o & activity_i;
		end
	end

	// ==========================================================
	// Sleep pattern tracker and deep sleep wake in standalone mode.
	reg [1:0] slp_state;
	reg [1:0] next_slp_state;
	reg       next_sleep;

	// Watch for high, low, high on the sleep control input.
	// Only a full sequence counts; the input is already two flops deep here,
	// so a slow edge cannot be seen twice.
	always @* begin
		next_slp_state = slp_state;
		next_sleep     = 1'b0;
		case (slp_state)
			`RCP_SLP_HIGH:  if (!s_sleep) next_slp_state = `RCP_SLP_LOW;
			`RCP_SLP_LOW:   if (s_sleep) begin
				next_slp_state = `RCP_SLP_HIGH;
				next_sleep     = 1'b1;
			end
			default:        next_slp_state = `RCP_SLP_HIGH;
		endcase
	end

	// Leaving standalone mode cancels sleep and restarts the pattern tracker.
	// Deep sleep follows sleep once no control or record input is active.
	always @(posedge clk_i) begin
		if (srst) begin
			slp_state    <= `RCP_SLP_HIGH;
			sleep_o      <= 1'b0;
			deep_sleep_o <= 1'b0;
		end else if (!standalone) begin
			slp_state    <= `RCP_SLP_HIGH;
			sleep_o      <= 1'b0;
			deep_sleep_o <= 1'b0;
		end else begin
			slp_state <= next_slp_state;
			if (next_sleep && !sleep_o)
				sleep_o <= 1'b1;
			else if (!s_ctrl_n || !s_rec_n)
				sleep_o <= 1'b0;
			deep_sleep_o <= sleep_o & s_ctrl_n & s_rec_n;
		end
	end

	// ==========================================================
	// Mode decode, recording and busy status.
	// Busy also covers the flash probe, so a host that polls it after reset
	// waits for the probe to settle before it sends anything.
	always @(posedge clk_i) begin
		if (srst) begin
			iface_mode_o <= `RCP_IF_SPI;
			recording_o  <= 1'b0;
			busy_o       <= 1'b1;
		end else begin
			iface_mode_o <= s_iface;
			recording_o  <= standalone & ~s_rec_n;
			busy_o       <= activity_i | probe_active_o | recording_o;
		end
	end

	// ==========================================================
	// Clock source choice and resonator pin enables.
	// The clock itself is switched outside this block; only the choice is kept.
	always @(posedge clk_i) begin
		if (srst) begin
			clk_from_resonator_o <= 1'b0;
			resonator_pins_en_o  <= 1'b0;
		end else begin
			clk_from_resonator_o <= s_res_sel;
			resonator_pins_en_o  <= s_res_sel;
		end
	end

	// ==========================================================
	// Sound output pin enables.
	// An unused configuration code leaves every sound pin undriven.
	always @(posedge clk_i) begin
		if (srst) begin
			speaker_oe_o  <= 1'b0;
			bz_pair1_oe_o <= 1'b0;
			bz_pos_2_oe_o <= 1'b0;
			bz_neg_2_oe_o <= 1'b0;
		end else begin
			speaker_oe_o  <= (s_outcfg == `RCP_OUT_SPEAKER);
			bz_pair1_oe_o <= (s_outcfg == `RCP_OUT_BUZZ2) |
				(s_outcfg == `RCP_OUT_BUZZ4);
			bz_pos_2_oe_o <= (s_outcfg == `RCP_OUT_BUZZ4);
			bz_neg_2_oe_o <= (s_outcfg == `RCP_OUT_BUZZ4);
		end
	end
endmodule // rcp_top

// ### test/rcp_top_properties.sv
`timescale 1ns/10ps
// ==========================================================
// Port-level checks of the reset, clock and pin-state block.
module rcp_top_properties #(
	parameter RST_MIN_CYC = 10,
	parameter PROBE_CYC   = 20,
	parameter CNT_W       = 8
) (
	input wire       clk_i,
	input wire       rst_i,
	input wire       reset_n_i,
	input wire       por_hold_i,
	input wire       bor_low_i,
	input wire       resonator_select_i,
	input wire [1:0] iface_select_i,
	input wire       host_reset_cmd_i,
	input wire       sound_output_setup_request_i,
	input wire       sys_reset_o,
	input wire       busy_o,
	input wire       amp_enable_out_oe_o,
	input wire       probe_active_o,
	input wire       clk_from_resonator_o,
	input wire       resonator_pins_en_o,
	input wire       fault_channel_a_o,
	input wire       fault_channel_b_o,
	input wire       error_o,
	input wire       speaker_oe_o,
	input wire       bz_pair1_oe_o,
	input wire       bz_pos_2_oe_o,
	input wire       bz_neg_2_oe_o
);
	reg [7:0] lo_run;
	reg [7:0] calm;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Counts low cycles of the pin and quiet cycles since any real reset cause.
	always @(posedge clk_i) begin
		lo_run <= reset_n_i ? 8'h00 : lo_run + 8'h01;
		if (rst_i || por_hold_i || bor_low_i || host_reset_cmd_i ||
				({24'h0, lo_run} + 32'd2 >= RST_MIN_CYC))
			calm <= 8'h00;
		else if (calm != 8'hff)
			calm <= calm + 8'h01;
	end
	a_pin_reset_taken: assert property (!reset_n_i[*8] |-> ##[0:3] sys_reset_o)
		else $error("long reset pulse not taken");
	a_short_pulse_dropped: assert property (calm > 8'h18 |-> !sys_reset_o)
		else $error("reset without a valid cause");
	a_supply_hold: assert property ((por_hold_i || bor_low_i)[*4] |-> sys_reset_o)
		else $error("supply hold not in reset");
	a_amp_release: assert property ((sound_output_setup_request_i &&
		iface_select_i != 2'b11 && !sys_reset_o)[*4] |-> ##[0:3] amp_enable_out_oe_o)
		else $error("amplifier pin not driven after request");
	a_busy_probe: assert property (probe_active_o[*2] |-> busy_o)
		else $error("busy low while probing");
	a_speaker_alone: assert property (speaker_oe_o |->
		!(bz_pair1_oe_o || bz_pos_2_oe_o || bz_neg_2_oe_o))
		else $error("buzzer driven with speaker");
	a_buzz4_pairs: assert property (bz_pos_2_oe_o |->
		bz_neg_2_oe_o && bz_pair1_oe_o && !speaker_oe_o)
		else $error("second buzzer pair incomplete");
	a_res_pins_on: assert property ((resonator_select_i && !sys_reset_o)[*5] |->
		resonator_pins_en_o && clk_from_resonator_o)
		else $error("resonator not selected");
	a_res_pins_off: assert property (!resonator_select_i[*4] |->
		!resonator_pins_en_o && !clk_from_resonator_o)
		else $error("resonator pins enabled");
	a_error_flag: assert property ($stable({fault_channel_a_o, fault_channel_b_o}) |->
		error_o == (fault_channel_a_o | fault_channel_b_o))
		else $error("error output mismatch");
	c_reset_end: cover property (sys_reset_o ##1 !sys_reset_o);
	c_buzz4: cover property (bz_pos_2_oe_o);
	c_amp: cover property (amp_enable_out_oe_o);
endmodule // rcp_top_properties

// ### test/rcp_host_model.sv
`timescale 1ns/10ps
// ==========================================================
// Host and flash stand-in: reset command pulses and probe answer.
module rcp_host_model (
	input  wire clk_i,
	input  wire go_i,
	input  wire forced_i,
	input  wire probe_i,
	input  wire fitted_i,
	output reg  cmd_o,
	output reg  forced_o,
	output reg  answer_o
);
	reg [2:0] hold;
	initial begin
		cmd_o = 1'b0;
		forced_o = 1'b0;
		answer_o = 1'b0;
		hold = 3'h0;
	end
	// Selection settles a cycle before the command edge and stays through it.
	always @(posedge clk_i) begin
		if (go_i) begin
			forced_o <= forced_i;
			hold <= 3'h4;
		end else if (hold != 3'h0)
			hold <= hold - 3'h1;
		cmd_o <= (hold > 3'h2);
		answer_o <= fitted_i & probe_i;
	end
endmodule // rcp_host_model

// ### test/tb_top.sv
`timescale 1ns/10ps
// ==========================================================
// Self-checking bench for the reset, clock and pin-state block.
module tb_top;
	reg        clk_i, rst_i, reset_n_i, por_hold_i, bor_low_i, resonator_select_i, activity_i;
	reg  [1:0] iface_select_i, sound_out_cfg_i;
	reg        sound_output_setup_request_i, param_amp_enable_i, fault_a_set_i, fault_b_set_i;
	reg        sleep_ctrl_i, record_hold_n_i, control_any_n_i, go, forced, fitted, seen;
	wire       host_reset_cmd_i, host_reset_forced_i, flash_answer_i, sys_reset_o, busy_o;
	wire       amp_enable_out_o, amp_enable_out_oe_o, ext_flash_pins_oe_o, probe_active_o;
	wire       clk_from_resonator_o, resonator_pins_en_o, fault_channel_a_o, fault_channel_b_o;
	wire       error_o, recording_o, sleep_o, deep_sleep_o, speaker_oe_o, bz_pair1_oe_o;
	wire       bz_pos_2_oe_o, bz_neg_2_oe_o;
	wire [1:0] iface_mode_o;
	integer    n_fail, check_count, cyc, i;
	reg  [31:0] lf;
	reg  [4:0] v;
	rcp_top #(.RST_MIN_CYC(4), .PROBE_CYC(8)) dut_u (.clk_i, .rst_i, .reset_n_i, .por_hold_i,
		.bor_low_i, .resonator_select_i, .iface_select_i, .host_reset_cmd_i,
		.host_reset_forced_i, .sound_output_setup_request_i, .sound_out_cfg_i,
		.param_amp_enable_i, .activity_i, .fault_a_set_i, .fault_b_set_i, .flash_answer_i,
		.sleep_ctrl_i, .record_hold_n_i, .control_any_n_i, .sys_reset_o, .busy_o,
		.amp_enable_out_o, .amp_enable_out_oe_o, .ext_flash_pins_oe_o, .probe_active_o,
		.clk_from_resonator_o, .resonator_pins_en_o, .fault_channel_a_o, .fault_channel_b_o,
		.error_o, .recording_o, .sleep_o, .deep_sleep_o, .speaker_oe_o, .bz_pair1_oe_o,
		.bz_pos_2_oe_o, .bz_neg_2_oe_o, .iface_mode_o);
	rcp_host_model hm_u (.clk_i(clk_i), .go_i(go), .forced_i(forced), .probe_i(probe_active_o),
		.fitted_i(fitted), .cmd_o(host_reset_cmd_i), .forced_o(host_reset_forced_i),
		.answer_o(flash_answer_i));
	function [31:0] nxt(input [31:0] x);
		nxt = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// Output enables as {speaker, buzzer pair 1, buzzer pos 2, buzzer neg 2}.
	function [3:0] oe_exp(input [1:0] c);
		oe_exp = (c == 2'b00) ? 4'h8 : (c == 2'b01) ? 4'h4 : 4'h7;
	endfunction
	task wt(input integer n);
		repeat (n) @(posedge clk_i);
	endtask
	task pk(input integer n);
		begin
			repeat (n) @(posedge clk_i);
			@(negedge clk_i);
		end
	endtask
	task chk(input [63:0] nm, input [3:0] e, input [3:0] g);
		begin
			check_count = check_count + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("[ERR] %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task watch(input integer n);
		begin
			seen = 1'b0;
			repeat (n) begin
				@(negedge clk_i);
				if (sys_reset_o === 1'b1) seen = 1'b1;
			end
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", check_count, n_fail);
			if (n_fail == 0 && check_count > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	// Clock generation and a hang limit.
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_fail = n_fail + 1;
			finish_test;
		end
	end
	// Main sequence.
	initial begin
		{rst_i, reset_n_i, sleep_ctrl_i, record_hold_n_i, control_any_n_i, fitted} = 6'h3f;
		{por_hold_i, bor_low_i, resonator_select_i, activity_i, go, forced} = 6'h00;
		{sound_output_setup_request_i, param_amp_enable_i, fault_a_set_i, fault_b_set_i} = 4'h0;
		{iface_select_i, sound_out_cfg_i} = 4'h0;
		n_fail = 0; check_count = 0; cyc = 0; lf = 32'h204a1164;
		wt(5); rst_i <= 1'b0;
		pk(14); chk("flash", 1, ext_flash_pins_oe_o);
		chk("probe", 0, probe_active_o);
		for (i = 0; i < 12; i = i + 1) begin
			lf = nxt(lf);
			v = (i < 4) ? {i[1:0], i[0], i[1:0]} : lf[4:0];
			wt(1); iface_select_i <= v[1:0]; resonator_select_i <= v[2]; activity_i <= lf[5];
			sound_out_cfg_i <= (v[4:3] == 2'b11) ? 2'b00 : v[4:3];
			pk(5);
			chk("iface", v[1:0], iface_mode_o);
			chk("resclk", v[2], clk_from_resonator_o);
			chk("respin", v[2], resonator_pins_en_o);
			chk("outoe", oe_exp(sound_out_cfg_i),
				{speaker_oe_o, bz_pair1_oe_o, bz_pos_2_oe_o, bz_neg_2_oe_o});
			chk("busy", lf[5], busy_o);
		end
		$display("test routing done");
		wt(1); iface_select_i <= 2'b00; activity_i <= 1'b1;
		pk(5); chk("amp_hz", 0, amp_enable_out_oe_o);
		chk("amp_lo", 0, amp_enable_out_o);
		wt(1); sound_output_setup_request_i <= 1'b1;
		pk(6); chk("amp_on", 1, amp_enable_out_oe_o);
		chk("amp_out", 1, amp_enable_out_o);
		wt(1); sound_output_setup_request_i <= 1'b0; fault_a_set_i <= 1'b1; fault_b_set_i <= 1'b1;
		wt(1); fault_a_set_i <= 1'b0; fault_b_set_i <= 1'b0; activity_i <= 1'b0;
		pk(3); chk("err", 3'h7, {fault_channel_a_o, fault_channel_b_o, error_o});
		wt(1); go <= 1'b1; forced <= 1'b0;
		wt(1); go <= 1'b0;
		pk(10); chk("clear", 0, {fault_channel_a_o, fault_channel_b_o, error_o});
		chk("keep", 1, {sys_reset_o, amp_enable_out_oe_o});
		wt(1); go <= 1'b1; forced <= 1'b1;
		wt(1); go <= 1'b0;
		watch(12); chk("forced", 1, seen);
		pk(20); chk("reinit", 0, amp_enable_out_oe_o);
		$display("test host command done");
		wt(1); iface_select_i <= 2'b11; param_amp_enable_i <= 1'b1;
		pk(6); chk("amp_sa", 1, amp_enable_out_oe_o);
		wt(1); sleep_ctrl_i <= 1'b0;
		wt(4); sleep_ctrl_i <= 1'b1;
		pk(5); chk("sleep", 1, sleep_o);
		chk("deep", 1, deep_sleep_o);
		wt(1); record_hold_n_i <= 1'b0;
		pk(5); chk("wake", 0, sleep_o);
		chk("nodeep", 0, deep_sleep_o);
		chk("rec", 3, {recording_o, busy_o});
		wt(1); record_hold_n_i <= 1'b1;
		pk(5); chk("recoff", 0, recording_o);
		$display("test standalone done");
		wt(1); fitted <= 1'b0; reset_n_i <= 1'b0;
		wt(2); reset_n_i <= 1'b1;
		watch(10); chk("short", 0, seen);
		wt(1); reset_n_i <= 1'b0;
		pk(8); chk("pinrst", 1, sys_reset_o);
		wt(1); reset_n_i <= 1'b1;
		pk(20); chk("noflash", 0, ext_flash_pins_oe_o);
		chk("probeto", 0, probe_active_o);
		wt(1); por_hold_i <= 1'b1;
		pk(4); chk("por", 1, sys_reset_o);
		wt(1); por_hold_i <= 1'b0; bor_low_i <= 1'b1;
		pk(4); chk("bor", 1, sys_reset_o);
		wt(1); bor_low_i <= 1'b0;
		pk(8); chk("supok", 0, sys_reset_o);
		$display("test reset sources done");
		finish_test;
	end
endmodule // tb_top

// Port-level checker bound into every instance of the block.
bind rcp_top rcp_top_properties #(.RST_MIN_CYC(RST_MIN_CYC), .PROBE_CYC(PROBE_CYC),
	.CNT_W(CNT_W)) chk_u (.clk_i, .rst_i, .reset_n_i, .por_hold_i, .bor_low_i,
	.resonator_select_i, .iface_select_i, .host_reset_cmd_i, .sound_output_setup_request_i,
	.sys_reset_o, .busy_o, .amp_enable_out_oe_o, .probe_active_o, .clk_from_resonator_o,
	.resonator_pins_en_o, .fault_channel_a_o, .fault_channel_b_o, .error_o, .speaker_oe_o,
	.bz_pair1_oe_o, .bz_pos_2_oe_o, .bz_neg_2_oe_o);
